// ---- core/ciops_core.sv ----
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ciops_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    logic [7:0]  work_reg,     work_next;
    logic [3:0]  stat_reg,     stat_next;
    logic        assign_reg,   assign_next;
    logic [7:0]  wdog_reg,     wdog_next;
    logic [7:0]  div_reg,      div_next;
    logic [5:0]  faddr_reg,    faddr_next;
    logic [31:0] prdata_reg,   prdata_next;
    logic        pready_reg,   pready_next;
    logic        pslverr_reg,  pslverr_next;
    logic [7:0]  file_mem [ciops_pkg::FILE_DEPTH];
    logic        file_we;
    logic [5:0]  file_wa;
    logic [7:0]  file_wd;
    logic        acc_done, wr_done, exec;
    logic        mapped;
    ciops_pkg::ciops_op_t op;
    logic [5:0]  fa;
    logic        tsel;
    logic [7:0]  fval;
    logic [8:0]  diff;
    logic [7:0]  res;

    assign acc_done = psel & penable & pready_reg;
    assign wr_done  = acc_done & pwrite;
    assign exec     = wr_done & (paddr == ciops_pkg::CMD_OFF);
    assign op       = ciops_pkg::ciops_op_t'(pwdata[ciops_pkg::CMD_OP_LSB +: 3]);
    assign fa       = pwdata[ciops_pkg::CMD_FA_LSB +: ciops_pkg::FILE_AW];
    assign tsel     = pwdata[ciops_pkg::CMD_TSEL_BIT];
    assign fval     = file_mem[fa];
    assign diff     = {1'b0, fval} - {1'b0, work_reg};
    assign mapped   = (paddr == ciops_pkg::CMD_OFF)  || (paddr == ciops_pkg::WORK_OFF)
                   || (paddr == ciops_pkg::STAT_OFF) || (paddr == ciops_pkg::CTRL_OFF)
                   || (paddr == ciops_pkg::WDOG_OFF) || (paddr == ciops_pkg::FADDR_OFF)
                   || (paddr == ciops_pkg::FDATA_OFF);

    // Instruction execution and software register writes
    always_comb begin
        work_next   = work_reg;
        stat_next   = stat_reg;
        assign_next = assign_reg;
        faddr_next  = faddr_reg;
        wdog_next   = wdog_reg + 8'h01;
        div_next    = div_reg + 8'h01;
        file_we     = 1'b0;
        file_wa     = fa;
        file_wd     = 8'h00;
        res         = 8'h00;
        if (exec) begin
            case (op)
                ciops_pkg::CIOPS_ZERO_WORK_OP: begin
                    work_next = 8'h00;
                    stat_next[ciops_pkg::ST_ZERO_BIT] = 1'b1;
                end
                ciops_pkg::CIOPS_KICK_WDOG_OP: begin
                    wdog_next = 8'h00;
                    if (assign_reg) begin
                        div_next = 8'h00;
                    end
                    stat_next[ciops_pkg::ST_EXP_BIT]   = 1'b1;
                    stat_next[ciops_pkg::ST_SLEEP_BIT] = 1'b1;
                end
                ciops_pkg::CIOPS_ZERO_FILE_OP: begin
                    file_we = 1'b1;
                    stat_next[ciops_pkg::ST_ZERO_BIT] = 1'b1;
                end
                ciops_pkg::CIOPS_INVERT_FILE_OP,
                ciops_pkg::CIOPS_COUNT_DOWN_OP: begin
                    res = (op == ciops_pkg::CIOPS_INVERT_FILE_OP) ? ~fval
                                                                  : fval - 8'h01;
                    stat_next[ciops_pkg::ST_ZERO_BIT] = (res == 8'h00);
                    if (tsel) begin
                        file_we = 1'b1;
                        file_wd = res;
                    end else begin
                        work_next = res;
                    end
                end
                ciops_pkg::CIOPS_COMPARE_OP: begin
                    stat_next[ciops_pkg::ST_ZERO_BIT]  = (diff[7:0] == 8'h00);
                    stat_next[ciops_pkg::ST_CARRY_BIT] = ~diff[8];
                end
                default: begin
                end
            endcase
        end else if (wr_done) begin
            case (paddr)
                ciops_pkg::WORK_OFF:  work_next   = pwdata[7:0];
                ciops_pkg::STAT_OFF:  stat_next   = pwdata[3:0];
                ciops_pkg::CTRL_OFF:  assign_next = pwdata[0];
                ciops_pkg::FADDR_OFF: faddr_next  = pwdata[5:0];
                ciops_pkg::FDATA_OFF: begin
                    file_we = 1'b1;
                    file_wa = faddr_reg;
                    file_wd = pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // APB answer: ready one cycle after setup, read data captured at setup
    always_comb begin
        pready_next  = psel & ~penable;
        pslverr_next = psel & ~penable & ~mapped;
        prdata_next  = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ciops_pkg::WORK_OFF:  prdata_next = {24'h00_0000, work_reg};
                ciops_pkg::STAT_OFF:  prdata_next = {28'h000_0000, stat_reg};
                ciops_pkg::CTRL_OFF:  prdata_next = {31'h0000_0000, assign_reg};
                ciops_pkg::WDOG_OFF:  prdata_next = {16'h0000, div_reg, wdog_reg};
                ciops_pkg::FADDR_OFF: prdata_next = {26'h000_0000, faddr_reg};
                ciops_pkg::FDATA_OFF: prdata_next = {24'h00_0000, file_mem[faddr_reg]};
                default:              prdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_reg    <= ciops_pkg::WORK_RESET;
            stat_reg    <= ciops_pkg::STAT_RESET;
            assign_reg  <= ciops_pkg::DIV_ASSIGN_RESET;
            wdog_reg    <= 8'h00;
            div_reg     <= 8'h00;
            faddr_reg   <= 6'h00;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            work_reg    <= work_next;
            stat_reg    <= stat_next;
            assign_reg  <= assign_next;
            wdog_reg    <= wdog_next;
            div_reg     <= div_next;
            faddr_reg   <= faddr_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // File register array, one entry per generate step
    for (genvar i = 0; i < ciops_pkg::FILE_DEPTH; i++) begin : g_file
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                file_mem[i] <= 8'h00;
            end else if (file_we && file_wa == 6'(i)) begin
                file_mem[i] <= file_wd;
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_zero_work_clears: assert property (exec && op == ciops_pkg::CIOPS_ZERO_WORK_OP
        |=> work_reg == 8'h00 && stat_reg[0]) else $error("work clear failed");
    a_kick_counter_zero: assert property (exec && op == ciops_pkg::CIOPS_KICK_WDOG_OP
        |=> wdog_reg == 8'h00 && (div_reg == 8'h00) == ($past(assign_reg) || $past(div_reg) == 8'hff))
        else $error("watchdog kick did not clear");
    a_kick_status_only: assert property (exec && op == ciops_pkg::CIOPS_KICK_WDOG_OP
        |=> stat_reg == {2'b11, $past(stat_reg[1:0])}) else $error("kick status wrong");
    a_zero_file_clears: assert property (exec && op == ciops_pkg::CIOPS_ZERO_FILE_OP
        |=> file_mem[$past(fa)] == 8'h00 && stat_reg[0]) else $error("file clear failed");
    a_invert_dest_ok: assert property (exec && op == ciops_pkg::CIOPS_INVERT_FILE_OP && !tsel
        |=> work_reg == ~$past(fval) && stat_reg[0] == (work_reg == 8'h00))
        else $error("invert to work wrong");
    a_compare_flags_ok: assert property (exec && op == ciops_pkg::CIOPS_COMPARE_OP
        |=> stat_reg[1] == ($past(fval) >= $past(work_reg))
            && stat_reg[0] == ($past(fval) == $past(work_reg))
            && stat_reg[3:2] == $past(stat_reg[3:2])) else $error("compare flags wrong");
    a_compare_keeps_data: assert property (exec && op == ciops_pkg::CIOPS_COMPARE_OP
        |=> $stable(work_reg) && file_mem[$past(fa)] == $past(fval))
        else $error("compare changed data");
    a_count_down_file: assert property (exec && op == ciops_pkg::CIOPS_COUNT_DOWN_OP && tsel
        |=> file_mem[$past(fa)] == $past(fval) - 8'h01 && $stable(work_reg)
            && stat_reg[0] == ($past(fval) == 8'h01)) else $error("count down wrong");
    a_apb_ready_once: assert property (psel && !penable |=> pready_reg ##1 !pready_reg)
        else $error("ready timing wrong");

    c_kick_assigned: cover property (exec && op == ciops_pkg::CIOPS_KICK_WDOG_OP && assign_reg);
    c_compare_equal: cover property (exec && op == ciops_pkg::CIOPS_COMPARE_OP && diff == 9'h000);
    c_count_wraps:   cover property (exec && op == ciops_pkg::CIOPS_COUNT_DOWN_OP && fval == 8'h00);
    c_unmapped:      cover property (acc_done && pslverr_reg);
endmodule : ciops_core

// ---- core/ciops_pkg.sv ----
// Contract
// - Clearing the work register loads zero and sets the zero flag.
// - Watchdog kick zeroes the counter, and the divider only when assigned to it.
// - Watchdog kick sets expiry and sleep flags; no other status bit changes.
// - Clearing a file register writes zero at address 0..63 and sets zero flag.
// - Invert complements the register, updates zero, target bit picks work or file.
// - Compare forms register minus work register; only zero and carry flags change.
// - Compare discards the difference; work and file registers stay unchanged.
// - Count down subtracts one, updates zero, target bit picks work or file.
package ciops_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 8;
    localparam int          FILE_AW      = 6;
    localparam int          FILE_DEPTH   = 64;
    localparam logic [7:0]  CMD_OFF      = 8'h00;
    localparam logic [7:0]  WORK_OFF     = 8'h04;
    localparam logic [7:0]  STAT_OFF     = 8'h08;
    localparam logic [7:0]  CTRL_OFF     = 8'h0c;
    localparam logic [7:0]  WDOG_OFF     = 8'h10;
    localparam logic [7:0]  FADDR_OFF    = 8'h14;
    localparam logic [7:0]  FDATA_OFF    = 8'h18;
    localparam int          CMD_OP_LSB   = 0;
    localparam int          CMD_FA_LSB   = 8;
    localparam int          CMD_TSEL_BIT = 16;
    localparam int          ST_ZERO_BIT  = 0;
    localparam int          ST_CARRY_BIT = 1;
    localparam int          ST_EXP_BIT   = 2;
    localparam int          ST_SLEEP_BIT = 3;
    localparam logic [3:0]  STAT_RESET   = 4'hc;
    localparam logic [7:0]  WORK_RESET   = 8'h00;
    localparam logic        DIV_ASSIGN_RESET = 1'b1;

    typedef enum logic [2:0] {
        CIOPS_NOP_OP         = 3'b000,
        CIOPS_ZERO_WORK_OP   = 3'b001,
        CIOPS_KICK_WDOG_OP   = 3'b010,
        CIOPS_ZERO_FILE_OP   = 3'b011,
        CIOPS_INVERT_FILE_OP = 3'b100,
        CIOPS_COMPARE_OP     = 3'b101,
        CIOPS_COUNT_DOWN_OP  = 3'b110
    } ciops_op_t;
endpackage : ciops_pkg

// ---- tb/ciops_core_tb.sv ----
`timescale 1ns/1ps
module ciops_core_tb;
    typedef struct packed {
        logic [2:0] op;
        logic       ts;
        logic [5:0] a;
        logic [7:0] w;
        logic [7:0] f;
        logic [3:0] ps;
        logic [7:0] ew;
        logic [7:0] ef;
        logic [3:0] es;
    } ciops_row_t;
    // Op, target, address, work, file, status before; work, file, status after
    localparam ciops_row_t ROWS [10] = '{
        '{3'h1, 1'h0, 6'h05, 8'h55, 8'h33, 4'h2, 8'h00, 8'h33, 4'h3},
        '{3'h2, 1'h0, 6'h06, 8'h12, 8'h34, 4'h3, 8'h12, 8'h34, 4'hf},
        '{3'h3, 1'h0, 6'h3f, 8'h12, 8'h55, 4'h0, 8'h12, 8'h00, 4'h1},
        '{3'h4, 1'h1, 6'h00, 8'h12, 8'ha6, 4'h3, 8'h12, 8'h59, 4'h2},
        '{3'h4, 1'h0, 6'h21, 8'h12, 8'hff, 4'h0, 8'h00, 8'hff, 4'h1},
        '{3'h5, 1'h0, 6'h10, 8'h12, 8'h34, 4'h1, 8'h12, 8'h34, 4'h2},
        '{3'h5, 1'h1, 6'h11, 8'h12, 8'h12, 4'h0, 8'h12, 8'h12, 4'h3},
        '{3'h5, 1'h0, 6'h12, 8'h12, 8'h11, 4'h3, 8'h12, 8'h11, 4'h0},
        '{3'h6, 1'h1, 6'h13, 8'h44, 8'h01, 4'h2, 8'h44, 8'h00, 4'h3},
        '{3'h6, 1'h0, 6'h14, 8'h55, 8'h00, 4'h1, 8'hff, 8'h00, 4'h0}
    };
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rdata;
    logic        rerr;
    logic [7:0]  d0;
    logic [7:0]  dd;
    ciops_row_t  r;
    int          mismatches;
    int          num_checks;

    ciops_core ciops_core_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    always #50 pclk = ~pclk;

    task final_report;
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; samples pready at rising edges under a bound
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n < 16) begin
            rdata = prdata;
            rerr  = pslverr;
        end else begin
            mismatches++;
            $display("MISMATCH t=%0t no pready", $time);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        num_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            r = ROWS[i];
            xfer(1'b1, ciops_pkg::WORK_OFF, {24'h0, r.w});
            xfer(1'b1, ciops_pkg::FADDR_OFF, {26'h0, r.a});
            xfer(1'b1, ciops_pkg::FDATA_OFF, {24'h0, r.f});
            xfer(1'b1, ciops_pkg::STAT_OFF, {28'h0, r.ps});
            xfer(1'b1, ciops_pkg::CMD_OFF, {15'h0, r.ts, 2'h0, r.a, 5'h0, r.op});
            xfer(1'b0, ciops_pkg::WORK_OFF, 32'h0);
            check(rdata, {24'h0, r.ew});
            xfer(1'b0, ciops_pkg::FDATA_OFF, 32'h0);
            check(rdata, {24'h0, r.ef});
            xfer(1'b0, ciops_pkg::STAT_OFF, 32'h0);
            check(rdata, {28'h0, r.es});
            check({31'h0, rerr}, 32'h0);
        end
        // Reset in mid-run restores the documented state
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, ciops_pkg::STAT_OFF, 32'h0);
        check(rdata, {28'h0, ciops_pkg::STAT_RESET});
        xfer(1'b0, ciops_pkg::FDATA_OFF, 32'h0);
        check(rdata, 32'h0);
        xfer(1'b0, ciops_pkg::CTRL_OFF, 32'h0);
        check(rdata, 32'h1);
        // Unmapped address is refused
        xfer(1'b1, 8'h40, 32'hff);
        check({31'h0, rerr}, 32'h1);
        xfer(1'b0, 8'h40, 32'h0);
        check({rdata[30:0], rerr}, 32'h1);
        // Kick with divider assigned clears both counts
        xfer(1'b1, ciops_pkg::CMD_OFF, 32'h2);
        xfer(1'b0, ciops_pkg::WDOG_OFF, 32'h0);
        check({31'h0, rdata[7:0] < 8'h08 && rdata[15:8] < 8'h08}, 32'h1);
        // Kick with divider not assigned leaves the divider running
        xfer(1'b1, ciops_pkg::CTRL_OFF, 32'h0);
        xfer(1'b0, ciops_pkg::WDOG_OFF, 32'h0);
        d0 = rdata[15:8];
        xfer(1'b1, ciops_pkg::CMD_OFF, 32'h2);
        xfer(1'b0, ciops_pkg::WDOG_OFF, 32'h0);
        dd = rdata[15:8] - d0;
        check({31'h0, rdata[7:0] < 8'h08 && dd > 8'h03 && dd < 8'h10}, 32'h1);
        final_report();
    end
endmodule : ciops_core_tb
